// *** logic/ictm_timing_model.v ***
// instruction execution cycle-count model
`timescale 1ns/1ps
module ictm_timing_model (
    input  wire        i_mclk,
    input  wire        i_reset_n,
    input  wire        i_start,
    input  wire        i_ea1_flag,
    input  wire [3:0]  i_op1_mode,
    input  wire [3:0]  i_op1_base_mode,
    input  wire [1:0]  i_op1_scale,
    input  wire [1:0]  i_op1_access,
    input  wire [3:0]  i_op1_bus_cycles,
    input  wire [3:0]  i_op1_waits,
    input  wire        i_ea2_flag,
    input  wire [3:0]  i_op2_mode,
    input  wire [3:0]  i_op2_base_mode,
    input  wire [1:0]  i_op2_scale,
    input  wire [1:0]  i_op2_access,
    input  wire [3:0]  i_op2_bus_cycles,
    input  wire [3:0]  i_op2_waits,
    input  wire [3:0]  i_ea_dword_bus_cycles,
    input  wire [3:0]  i_ea_dword_waits,
    input  wire [1:0]  i_length,
    input  wire [3:0]  i_byte_xfers,
    input  wire [3:0]  i_word_xfers,
    input  wire [3:0]  i_dword_xfers,
    input  wire [3:0]  i_length_xfers,
    input  wire [7:0]  i_length_units,
    input  wire [11:0] i_overhead_min,
    input  wire [11:0] i_overhead_max,
    input  wire        i_flush,
    input  wire [11:0] i_flush_point,
    input  wire        i_fetch_multi,
    input  wire [11:0] i_fetch_time,
    input  wire        i_string_move_instr,
    input  wire [3:0]  i_string_writes,
    input  wire [3:0]  i_write_waits,
    input  wire        i_float,
    input  wire [1:0]  i_float_opcode_slot,
    input  wire        i_float_long,
    input  wire [3:0]  i_float_xfers,
    input  wire [3:0]  i_int_xfers,
    input  wire        i_int_dword,
    input  wire [11:0] i_parallel_cpu_cycles,
    input  wire [11:0] i_coprocessor_exec_cycles,
    output reg  [11:0] o_total_exec_min,
    output reg  [11:0] o_total_exec_max,
    output reg  [11:0] o_parallel_cycles_used,
    output reg         o_rmw_write_overlap,
    output reg         o_fetch_overlap,
    output reg         o_queue_flush,
    output reg         o_float_move_instr,
    output reg         o_float_add_instr,
    output reg  [1:0]  o_float_op2_access,
    output reg         o_result_undefined,
    output reg         o_done
);
`include "ictm_map.vh"
    wire [11:0] ea_dword_cost;
    wire [11:0] ea1_cost;
    wire [11:0] ea2_cost;
    wire [11:0] b1;
    wire [11:0] w1;
    wire [11:0] d1;
    wire [11:0] l1;
    wire [11:0] b2;
    wire [11:0] w2;
    wire [11:0] d2;
    wire [11:0] l2;
    function [11:0] mul4;
        input [11:0] a;
        input [3:0]  n;
        begin
            mul4 = a * {8'h00, n};
        end
    endfunction
    function [11:0] max12;
        input [11:0] a;
        input [11:0] b;
        begin
            max12 = (a > b) ? a : b;
        end
    endfunction
    ictm_xfer_cost u_eax (
        .i_in_memory            (1'b1),
        .i_length               (`ICTM_LEN_DWORD),
        .i_bus_cycles           (i_ea_dword_bus_cycles),
        .i_wait_states          (i_ea_dword_waits),
        .o_byte_transfer_cost   (),
        .o_word_transfer_cost   (),
        .o_dword_transfer_cost  (ea_dword_cost),
        .o_length_transfer_cost ()
    );
    ictm_ea_cost u_ea1 (
        .i_mode              (i_op1_mode),
        .i_base_mode         (i_op1_base_mode),
        .i_scale             (i_op1_scale),
        .i_access            (i_op1_access),
        .i_dword_cost        (ea_dword_cost),
        .o_address_calc_cost (ea1_cost)
    );
    ictm_ea_cost u_ea2 (
        .i_mode              (i_op2_mode),
        .i_base_mode         (i_op2_base_mode),
        .i_scale             (i_op2_scale),
        .i_access            (i_op2_access),
        .i_dword_cost        (ea_dword_cost),
        .o_address_calc_cost (ea2_cost)
    );
    wire op1_mem = !(i_op1_mode == `ICTM_MODE_REG || i_op1_mode == `ICTM_MODE_IMM);
    wire op2_mem = !(i_op2_mode == `ICTM_MODE_REG || i_op2_mode == `ICTM_MODE_IMM);
    ictm_xfer_cost u_x1 (
        .i_in_memory            (op1_mem),
        .i_length               (i_length),
        .i_bus_cycles           (i_op1_bus_cycles),
        .i_wait_states          (i_op1_waits),
        .o_byte_transfer_cost   (b1),
        .o_word_transfer_cost   (w1),
        .o_dword_transfer_cost  (d1),
        .o_length_transfer_cost (l1)
    );
    ictm_xfer_cost u_x2 (
        .i_in_memory            (op2_mem),
        .i_length               (i_length),
        .i_bus_cycles           (i_op2_bus_cycles),
        .i_wait_states          (i_op2_waits),
        .o_byte_transfer_cost   (b2),
        .o_word_transfer_cost   (w2),
        .o_dword_transfer_cost  (d2),
        .o_length_transfer_cost (l2)
    );
    reg [11:0] ea_sum;
    reg [11:0] xfer_sum;
    reg [11:0] len_mult;
    reg [11:0] len_term;
    reg [11:0] ovh_min;
    reg [11:0] ovh_max;
    reg [11:0] hide;
    reg [11:0] hidden;
    reg [11:0] fpu_term;
    reg [11:0] par_term;
    reg [11:0] nxt_min;
    reg [11:0] nxt_max;
    reg [1:0]  f_factor;
    always @* begin
        ea_sum = (i_ea1_flag ? ea1_cost : 12'h000) + (i_ea2_flag ? ea2_cost : 12'h000);
        xfer_sum = mul4(op1_mem ? b1 : b2, i_byte_xfers) + mul4(op1_mem ? w1 : w2, i_word_xfers)
                 + mul4(op1_mem ? d1 : d2, i_dword_xfers);
        xfer_sum = xfer_sum + mul4(l1 + l2, i_length_xfers);
        case (i_length)
            `ICTM_LEN_BYTE: len_mult = `ICTM_LMUL_BYTE;
            `ICTM_LEN_WORD: len_mult = `ICTM_LMUL_WORD;
            default:        len_mult = `ICTM_LMUL_DWORD;
        endcase
        len_term = {4'h0, i_length_units} * len_mult;
        // immediate operands share the register overhead entry
        ovh_min = i_overhead_min;
        ovh_max = max12(i_overhead_min, i_overhead_max);
        if (i_flush) begin
            ovh_min = i_flush_point + (i_fetch_multi ? `ICTM_FLUSH_MANY : `ICTM_FLUSH_ONE)
                    + i_fetch_time;
            ovh_max = ovh_min;
        end
        hide = (i_length == `ICTM_LEN_DWORD) ? `ICTM_MOVS_HIDE_D : `ICTM_MOVS_HIDE_BW;
        hidden = mul4(({8'h00, i_write_waits} > hide) ? hide : {8'h00, i_write_waits},
                      i_string_writes);
        if (i_string_move_instr) begin
            ovh_min = (ovh_min > hidden) ? ovh_min - hidden : 12'h000;
            ovh_max = (ovh_max > hidden) ? ovh_max - hidden : 12'h000;
        end
        f_factor = i_float_long ? `ICTM_FFAC_LONG : `ICTM_FFAC_STD;
        fpu_term = 12'h000;
        par_term = 12'h000;
        if (i_float) begin
            fpu_term = mul4(mul4(`ICTM_TF, {2'h0, f_factor}), i_float_xfers)
                     + mul4(i_int_dword ? `ICTM_TI_LONG : `ICTM_TI_SHORT, i_int_xfers);
            // coprocessor time counts from last data sent until done
            par_term = max12(i_parallel_cpu_cycles,
                             i_coprocessor_exec_cycles + `ICTM_FPU_EXTRA);
        end
        nxt_min = ea_sum + xfer_sum + len_term + ovh_min + fpu_term + par_term;
        nxt_max = ea_sum + xfer_sum + len_term + ovh_max + fpu_term + par_term;
    end
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_total_exec_min       <= 12'h000;
            o_total_exec_max       <= 12'h000;
            o_parallel_cycles_used <= 12'h000;
            o_rmw_write_overlap    <= 1'b0;
            o_fetch_overlap        <= 1'b0;
            o_queue_flush          <= 1'b0;
            o_float_move_instr     <= 1'b0;
            o_float_add_instr      <= 1'b0;
            o_float_op2_access     <= `ICTM_ACC_READ;
            o_result_undefined     <= 1'b0;
            o_done                 <= 1'b0;
        end else begin
            o_done <= i_start;
            if (i_start) begin
                o_total_exec_min       <= nxt_min;
                o_total_exec_max       <= nxt_max;
                o_parallel_cycles_used <= par_term;
                o_rmw_write_overlap    <= op2_mem && i_op2_access == `ICTM_ACC_RMW;
                o_fetch_overlap        <= op1_mem || op2_mem;
                o_queue_flush          <= i_flush;
                o_float_move_instr     <= i_float && i_float_opcode_slot == `ICTM_FOP_MOVE;
                o_float_add_instr      <= i_float && i_float_opcode_slot == `ICTM_FOP_ADD;
                o_float_op2_access     <= (i_float_opcode_slot == `ICTM_FOP_ADD) ?
                                          `ICTM_ACC_RMW : `ICTM_ACC_WRITE;
                o_result_undefined     <= i_float && i_float_opcode_slot == `ICTM_FOP_RSVD;
            end
        end
    end
endmodule

// *** pkg/ictm_map.vh ***
// cycle-cost constants for the instruction timing model
`ifndef ICTM_MAP_VH
`define ICTM_MAP_VH
`define ICTM_W           12
`define ICTM_MODE_IMM    4'h0
`define ICTM_MODE_ABS    4'h1
`define ICTM_MODE_EXT    4'h2
`define ICTM_MODE_MREL   4'h3
`define ICTM_MODE_REG    4'h4
`define ICTM_MODE_RREL   4'h5
`define ICTM_MODE_TOS    4'h6
`define ICTM_MODE_SIDX   4'h7
`define ICTM_ACC_READ    2'h0
`define ICTM_ACC_WRITE   2'h1
`define ICTM_ACC_RMW     2'h2
`define ICTM_LEN_BYTE    2'h0
`define ICTM_LEN_WORD    2'h1
`define ICTM_LEN_DWORD   2'h2
`define ICTM_SCL_BYTE    2'h0
`define ICTM_SCL_WORD    2'h1
`define ICTM_SCL_DWORD   2'h2
`define ICTM_SCL_QWORD   2'h3
`define ICTM_EA_IMM      12'h004
`define ICTM_EA_EXT      12'h00b
`define ICTM_EA_MREL     12'h007
`define ICTM_EA_REG      12'h002
`define ICTM_EA_RREL     12'h005
`define ICTM_EA_TOS_WR   12'h004
`define ICTM_EA_TOS_RD   12'h002
`define ICTM_EA_TOS_RMW  12'h003
`define ICTM_TI1_REG     12'h005
`define ICTM_TI1_TOS     12'h004
`define ICTM_TI2_BYTE    12'h005
`define ICTM_TI2_WORD    12'h007
`define ICTM_TI2_DWORD   12'h008
`define ICTM_TI2_QWORD   12'h00a
`define ICTM_BYTE_TRANSFER_COST_MEM    12'h003
`define ICTM_BUS_CYC     12'h004
`define ICTM_BUS_TRIM    12'h001
`define ICTM_LMUL_BYTE   12'h001
`define ICTM_LMUL_WORD   12'h002
`define ICTM_LMUL_DWORD  12'h004
`define ICTM_FFAC_STD    2'h1
`define ICTM_FFAC_LONG   2'h2
`define ICTM_FLUSH_ONE   12'h006
`define ICTM_FLUSH_MANY  12'h005
`define ICTM_MOVS_HIDE_BW 12'h00d
`define ICTM_MOVS_HIDE_D 12'h004
`define ICTM_TF          12'h004
`define ICTM_TI_SHORT    12'h002
`define ICTM_TI_LONG     12'h004
`define ICTM_FPU_EXTRA   12'h003
`define ICTM_FOP_MOVE    2'h1
`define ICTM_FOP_ADD     2'h2
`define ICTM_FOP_RSVD    2'h3
`endif

// *** logic/ictm_ea_cost.v ***
// effective-address cost for one operand
`timescale 1ns/1ps
module ictm_ea_cost (
    input  wire [3:0]  i_mode,
    input  wire [3:0]  i_base_mode,
    input  wire [1:0]  i_scale,
    input  wire [1:0]  i_access,
    input  wire [11:0] i_dword_cost,
    output wire [11:0] o_address_calc_cost
);
`include "ictm_map.vh"
    function [11:0] plain_cost;
        input [3:0]  mode;
        input [1:0]  acc;
        input [11:0] td;
        begin
            if (mode == `ICTM_MODE_IMM || mode == `ICTM_MODE_ABS)
                plain_cost = `ICTM_EA_IMM;
            else if (mode == `ICTM_MODE_EXT)
                plain_cost = `ICTM_EA_EXT + {td[10:0], 1'b0};
            else if (mode == `ICTM_MODE_MREL)
                plain_cost = `ICTM_EA_MREL + td;
            else if (mode == `ICTM_MODE_REG)
                plain_cost = `ICTM_EA_REG;
            else if (mode == `ICTM_MODE_RREL)
                plain_cost = `ICTM_EA_RREL;
            else if (mode == `ICTM_MODE_TOS) begin
                if (acc == `ICTM_ACC_WRITE)
                    plain_cost = `ICTM_EA_TOS_WR;
                else if (acc == `ICTM_ACC_RMW)
                    plain_cost = `ICTM_EA_TOS_RMW;
                else
                    plain_cost = `ICTM_EA_TOS_RD;
            end else
                plain_cost = 12'h000;
        end
    endfunction
    reg [11:0] base_c;
    reg [11:0] idx_c;
    always @* begin
        if (i_base_mode == `ICTM_MODE_REG)
            base_c = `ICTM_TI1_REG;
        else if (i_base_mode == `ICTM_MODE_TOS)
            base_c = `ICTM_TI1_TOS;
        else
            base_c = plain_cost(i_base_mode, i_access, i_dword_cost);
        case (i_scale)
            `ICTM_SCL_BYTE:  idx_c = `ICTM_TI2_BYTE;
            `ICTM_SCL_WORD:  idx_c = `ICTM_TI2_WORD;
            `ICTM_SCL_DWORD: idx_c = `ICTM_TI2_DWORD;
            default:         idx_c = `ICTM_TI2_QWORD;
        endcase
    end
    assign o_address_calc_cost = (i_mode == `ICTM_MODE_SIDX) ? base_c + idx_c :
                                 plain_cost(i_mode, i_access, i_dword_cost);
endmodule

// *** logic/ictm_xfer_cost.v ***
// operand transfer costs for byte, word, dword and operation length
`timescale 1ns/1ps
module ictm_xfer_cost (
    input  wire        i_in_memory,
    input  wire [1:0]  i_length,
    input  wire [3:0]  i_bus_cycles,
    input  wire [3:0]  i_wait_states,
    output wire [11:0] o_byte_transfer_cost,
    output wire [11:0] o_word_transfer_cost,
    output wire [11:0] o_dword_transfer_cost,
    output wire [11:0] o_length_transfer_cost
);
`include "ictm_map.vh"
    wire [11:0] operand_bus_cycle_count  = {8'h00, i_bus_cycles};
    wire [11:0] waits = {8'h00, i_wait_states};
    wire [11:0] wtot  = operand_bus_cycle_count * waits;
    wire [11:0] multi = (operand_bus_cycle_count == 12'h000) ? 12'h000 :
                        (operand_bus_cycle_count * `ICTM_BUS_CYC) - `ICTM_BUS_TRIM + wtot;
    assign o_byte_transfer_cost  = i_in_memory ? `ICTM_BYTE_TRANSFER_COST_MEM + waits :
                                   12'h000;
    assign o_word_transfer_cost  = i_in_memory ? multi : 12'h000;
    assign o_dword_transfer_cost = i_in_memory ? multi : 12'h000;
    assign o_length_transfer_cost = !i_in_memory ? 12'h000 :
                       (i_length == `ICTM_LEN_BYTE) ? o_byte_transfer_cost :
                       (i_length == `ICTM_LEN_WORD) ? o_word_transfer_cost :
                       o_dword_transfer_cost;
endmodule

// *** verification/ictm_far_model.sv ***
// memory bus and coprocessor stand-in: bus cycle counts and coprocessor time
`timescale 1ns/1ps
`include "ictm_map.vh"
module ictm_far_model #(
    parameter [11:0] FPU_CYCLES = 12'h013
) (
    input  wire [1:0]  i_size1,
    input  wire        i_unal1,
    input  wire [1:0]  i_size2,
    input  wire        i_unal2,
    output wire [3:0]  o_ncyc1,
    output wire [3:0]  o_ncyc2,
    output wire [3:0]  o_operand_bus_cycle_count_ptr,
    output wire [11:0] o_fpu_cycles
);
    function [3:0] operand_bus_cycle_count(input [1:0] sz, input un);
        operand_bus_cycle_count = (sz == `ICTM_LEN_BYTE) ? 4'h1 : (sz == `ICTM_LEN_WORD) ? 4'h1 + un : 4'h2 + un;
    endfunction
    assign o_ncyc1 = operand_bus_cycle_count(i_size1, i_unal1);
    assign o_ncyc2 = operand_bus_cycle_count(i_size2, i_unal2);
    assign o_operand_bus_cycle_count_ptr = 4'h2;
    assign o_fpu_cycles = FPU_CYCLES;
endmodule

// *** verification/ictm_timing_model_properties.sv ***
// checker for the instruction timing model outputs
`timescale 1ns/1ps
`include "ictm_map.vh"
module ictm_timing_model_properties (
    input wire        i_mclk,
    input wire        i_reset_n,
    input wire        i_start,
    input wire        i_flush,
    input wire        i_float,
    input wire [1:0]  i_float_opcode_slot,
    input wire [11:0] i_parallel_cpu_cycles,
    input wire [11:0] i_coprocessor_exec_cycles,
    input wire [11:0] o_total_exec_min,
    input wire [11:0] o_total_exec_max,
    input wire [11:0] o_parallel_cycles_used,
    input wire        o_queue_flush,
    input wire        o_float_move_instr,
    input wire        o_float_add_instr,
    input wire [1:0]  o_float_op2_access,
    input wire        o_result_undefined,
    input wire        o_done
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    wire [11:0] fpu_plus = i_coprocessor_exec_cycles + `ICTM_FPU_EXTRA;
    wire [11:0] par_ref  = (fpu_plus > i_parallel_cpu_cycles) ? fpu_plus : i_parallel_cpu_cycles;
    done_pulse_a: assert property (i_start |=> o_done)
        else $error("done missing after start");
    done_cause_a: assert property (o_done |-> $past(i_start))
        else $error("done without start");
    result_hold_a: assert property (
        !i_start |=> $stable(o_total_exec_min) && $stable(o_total_exec_max))
        else $error("result changed without start");
    range_order_a: assert property (o_done |-> o_total_exec_max >= o_total_exec_min)
        else $error("maximum below minimum");
    flush_flag_a: assert property (i_start |=> o_queue_flush == $past(i_flush))
        else $error("flush flag mismatch");
    par_max_a: assert property (
        i_start && i_float |=> o_parallel_cycles_used == $past(par_ref))
        else $error("parallel term not the larger one");
    move_slot_a: assert property (
        i_start && i_float && i_float_opcode_slot == `ICTM_FOP_MOVE |=>
        o_float_move_instr && !o_float_add_instr && o_float_op2_access == `ICTM_ACC_WRITE)
        else $error("move slot mapping wrong");
    add_slot_a: assert property (
        i_start && i_float && i_float_opcode_slot == `ICTM_FOP_ADD |=>
        o_float_add_instr && !o_float_move_instr && o_float_op2_access == `ICTM_ACC_RMW)
        else $error("add slot mapping wrong");
    rsvd_slot_a: assert property (
        i_start && i_float && i_float_opcode_slot == `ICTM_FOP_RSVD |=> o_result_undefined)
        else $error("reserved slot not flagged");
    cover property (i_start && i_flush);
    cover property (i_start && i_float);
    cover property (o_done && o_total_exec_max > o_total_exec_min);
endmodule
bind ictm_timing_model ictm_timing_model_properties ictm_timing_model_properties_i (.*);

// *** verification/ictm_timing_model_test.sv ***
// self-checking bench for the instruction timing model
`timescale 1ns/1ps
`include "ictm_map.vh"
module ictm_timing_model_test;
    logic        i_mclk, i_reset_n, i_start, i_ea1_flag, i_ea2_flag, i_flush, i_fetch_multi;
    logic        i_string_move_instr, i_float, i_float_long, i_int_dword, un1, un2;
    logic [3:0]  i_op1_mode, i_op1_base_mode, i_op2_mode, i_op2_base_mode, i_op1_waits;
    logic [3:0]  i_op2_waits, i_ea_dword_waits, i_byte_xfers, i_word_xfers, i_dword_xfers;
    logic [3:0]  i_length_xfers, i_string_writes, i_write_waits, i_float_xfers, i_int_xfers;
    logic [1:0]  i_op1_scale, i_op1_access, i_op2_scale, i_op2_access, i_length, sz1, sz2;
    logic [1:0]  i_float_opcode_slot;
    logic [7:0]  i_length_units;
    logic [11:0] i_overhead_min, i_overhead_max, i_flush_point, i_fetch_time;
    logic [11:0] i_parallel_cpu_cycles;
    wire  [3:0]  i_op1_bus_cycles, i_op2_bus_cycles, i_ea_dword_bus_cycles;
    wire  [11:0] i_coprocessor_exec_cycles, o_total_exec_min, o_total_exec_max;
    wire  [11:0] o_parallel_cycles_used;
    wire         o_rmw_write_overlap, o_fetch_overlap, o_queue_flush, o_float_move_instr;
    wire         o_float_add_instr, o_result_undefined, o_done;
    wire  [1:0]  o_float_op2_access;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          k;
    ictm_timing_model ictm_timing_model_i (.*);
    ictm_far_model #(.FPU_CYCLES(12'h013)) ictm_far_model_i (.i_size1(sz1), .i_unal1(un1),
        .i_size2(sz2), .i_unal2(un2), .o_ncyc1(i_op1_bus_cycles), .o_ncyc2(i_op2_bus_cycles),
        .o_operand_bus_cycle_count_ptr(i_ea_dword_bus_cycles), .o_fpu_cycles(i_coprocessor_exec_cycles));
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input [11:0] seen, input [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic clr;
        {i_ea1_flag, i_ea2_flag, i_flush, i_fetch_multi, i_string_move_instr} = '0;
        {i_float, i_float_long, i_int_dword, un1, un2, sz1, sz2, i_float_opcode_slot} = '0;
        {i_op1_mode, i_op1_base_mode, i_op2_mode, i_op2_base_mode, i_op1_waits} = '0;
        {i_op2_waits, i_ea_dword_waits, i_byte_xfers, i_word_xfers, i_dword_xfers} = '0;
        {i_length_xfers, i_string_writes, i_write_waits, i_float_xfers, i_int_xfers} = '0;
        {i_op1_scale, i_op1_access, i_op2_scale, i_op2_access, i_length, i_length_units} = '0;
        {i_overhead_min, i_overhead_max, i_flush_point, i_fetch_time} = '0;
        i_parallel_cpu_cycles = '0;
    endtask
    task automatic run(input string nm, input [11:0] mn, input [11:0] mx);
        i_start = 1'b1;
        @(posedge i_mclk);
        #1 i_start = 1'b0;
        clr();
        chk("done", {11'h0, o_done}, 12'h001);
        chk(nm, o_total_exec_min, mn);
        chk(nm, o_total_exec_max, mx);
        @(posedge i_mclk);
        #1;
    endtask
    task automatic ea(input [3:0] m, input [3:0] b, input [1:0] s, input [1:0] a, input [11:0] e);
        i_ea1_flag = 1'b1;
        {i_op1_mode, i_op1_base_mode, i_op1_scale, i_op1_access} = {m, b, s, a};
        run("address cost", e, e);
    endtask
    task automatic xf(input [3:0] m, input [1:0] sz, input un, input [3:0] w, input [1:0] len,
                      input [15:0] counts, input [11:0] e);
        {i_op1_mode, sz1, un1, i_op1_waits, i_length} = {m, sz, un, w, len};
        {i_byte_xfers, i_word_xfers, i_dword_xfers, i_length_xfers} = counts;
        run("transfer cost", e, e);
    endtask
    task automatic sm(input [1:0] len, input [3:0] w, input [11:0] e);
        {i_string_move_instr, i_length, i_string_writes, i_write_waits} = {1'b1, len, 4'h2, w};
        {i_overhead_min, i_overhead_max} = {12'h01e, 12'h01e};
        run("string move", e, e);
    endtask
    task automatic t_ea;
        ea(`ICTM_MODE_IMM, 4'h0, 2'h0, `ICTM_ACC_READ, 12'h004);
        ea(`ICTM_MODE_ABS, 4'h0, 2'h0, `ICTM_ACC_READ, 12'h004);
        ea(`ICTM_MODE_EXT, 4'h0, 2'h0, `ICTM_ACC_READ, 12'h019);
        ea(`ICTM_MODE_MREL, 4'h0, 2'h0, `ICTM_ACC_READ, 12'h00e);
        ea(`ICTM_MODE_REG, 4'h0, 2'h0, `ICTM_ACC_READ, 12'h002);
        ea(`ICTM_MODE_RREL, 4'h0, 2'h0, `ICTM_ACC_READ, 12'h005);
        ea(`ICTM_MODE_TOS, 4'h0, 2'h0, `ICTM_ACC_WRITE, 12'h004);
        ea(`ICTM_MODE_TOS, 4'h0, 2'h0, `ICTM_ACC_READ, 12'h002);
        ea(`ICTM_MODE_TOS, 4'h0, 2'h0, `ICTM_ACC_RMW, 12'h003);
        ea(`ICTM_MODE_SIDX, `ICTM_MODE_REG, `ICTM_SCL_BYTE, 2'h0, 12'h00a);
        ea(`ICTM_MODE_SIDX, `ICTM_MODE_TOS, `ICTM_SCL_QWORD, 2'h0, 12'h00e);
        ea(`ICTM_MODE_SIDX, `ICTM_MODE_RREL, `ICTM_SCL_WORD, 2'h0, 12'h00c);
        ea(`ICTM_MODE_SIDX, `ICTM_MODE_ABS, `ICTM_SCL_DWORD, 2'h0, 12'h00c);
        i_op1_mode = `ICTM_MODE_EXT;
        run("address flag off", 12'h000, 12'h000);
    endtask
    task automatic t_rest;
        xf(`ICTM_MODE_ABS, 2'h0, 1'b0, 4'h0, 2'h0, 16'h1000, 12'h003);
        xf(`ICTM_MODE_REG, 2'h0, 1'b0, 4'h0, 2'h0, 16'h1000, 12'h000);
        xf(`ICTM_MODE_ABS, 2'h0, 1'b0, 4'h2, 2'h0, 16'h1000, 12'h005);
        xf(`ICTM_MODE_ABS, 2'h1, 1'b1, 4'h1, 2'h0, 16'h0100, 12'h009);
        xf(`ICTM_MODE_ABS, 2'h2, 1'b0, 4'h0, 2'h0, 16'h0010, 12'h007);
        xf(`ICTM_MODE_ABS, 2'h2, 1'b1, 4'h0, 2'h2, 16'h0001, 12'h00b);
        xf(`ICTM_MODE_ABS, 2'h0, 1'b0, 4'h0, 2'h0, 16'h0001, 12'h003);
        for (k = 0; k < 3; k++) begin
            {i_length, i_length_units} = {k[1:0], 8'h03};
            run("length term", 12'h003 << k, 12'h003 << k);
        end
        {i_overhead_min, i_overhead_max} = {12'h005, 12'h009};
        run("overhead range", 12'h005, 12'h009);
        {i_overhead_min, i_overhead_max} = {12'h007, 12'h003};
        run("overhead range", 12'h007, 12'h007);
        chk("fetch overlap", {11'h0, o_fetch_overlap}, 12'h000);
        for (k = 0; k < 2; k++) begin
            {i_flush, i_fetch_multi} = {1'b1, k[0]};
            {i_flush_point, i_fetch_time} = {12'h004, 12'h003};
            run("flush", 12'h00d - k, 12'h00d - k);
            chk("queue flush", {11'h0, o_queue_flush}, 12'h001);
        end
        sm(`ICTM_LEN_WORD, 4'h5, 12'h014);
        sm(`ICTM_LEN_WORD, 4'hf, 12'h004);
        sm(`ICTM_LEN_DWORD, 4'h6, 12'h016);
        for (k = 0; k < 2; k++) begin
            {i_ea1_flag, i_ea2_flag, i_op1_mode} = {2'b11, `ICTM_MODE_REG};
            i_op2_mode = `ICTM_MODE_TOS;
            i_op2_access = k[0] ? `ICTM_ACC_RMW : `ICTM_ACC_READ;
            {i_length, i_length_xfers, sz2} = {`ICTM_LEN_WORD, 4'h1, `ICTM_LEN_WORD};
            {i_overhead_min, i_overhead_max} = {12'h003, 12'h003};
            run("basic total", 12'h00a + k, 12'h00a + k);
            chk("fetch overlap", {11'h0, o_fetch_overlap}, 12'h001);
            chk("rmw overlap", {11'h0, o_rmw_write_overlap}, k);
        end
    endtask
    task automatic t_float;
        {i_float, i_float_long, i_float_xfers, i_int_xfers, i_int_dword} = {2'b11, 8'h11, 1'b1};
        i_parallel_cpu_cycles = 12'h00a;
        run("float total", 12'h022, 12'h022);
        chk("parallel", o_parallel_cycles_used, 12'h016);
        {i_float, i_float_xfers, i_int_xfers, i_parallel_cpu_cycles} = {9'h111, 12'h01e};
        run("float total", 12'h024, 12'h024);
        for (k = 0; k < 4; k++) begin
            {i_float, i_float_opcode_slot} = {1'b1, k[1:0]};
            run("float slot", 12'h016, 12'h016);
            chk("move", {11'h0, o_float_move_instr}, {11'h0, k == 1});
            chk("add", {11'h0, o_float_add_instr}, {11'h0, k == 2});
            chk("undefined", {11'h0, o_result_undefined}, {11'h0, k == 3});
            if (k == 1 || k == 2) chk("op2 access", {10'h0, o_float_op2_access}, k);
        end
    endtask
    initial begin
        i_reset_n = 1'b0;
        i_start = 1'b0;
        clr();
        repeat (4) @(posedge i_mclk);
        #1 i_reset_n = 1'b1;
        t_ea();
        t_rest();
        t_float();
        tally_and_finish();
    end
endmodule
